/* File: hdl/lfc_host.sv */
// apb-controlled host that drives the flash command bus pins
`timescale 1ns/100ps
`include "lfc_regs.svh"
module lfc_host (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [18:0] flash_addr,
   input wire logic [15:0] flash_dq_in,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe,
   output logic chip_select_n,
   output logic output_gate_n,
   output logic write_strobe_n,
   output logic byte_mode_n,
   output logic reset_powerdown_n,
   input wire logic ready_busy_n,
   output logic [1:0] busy_state
);
   import lfc_pkg::*;
   // ============================================================
   // registers and state
   lfc_state_t state;
   logic [31:0] ctrl;
   logic [18:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic done;
   logic err;
   logic [9:0] count;
   logic [15:0] dq_s1, dq_s2;
   logic rb_s1, rb_s2;
   logic [2:0] writes_left;

   // ============================================================
   // apb decode
   wire apb_wr = psel && penable && pwrite;
   wire apb_rd_en = psel && !pwrite;
   wire hit_ctrl = paddr == `LFC_CTRL_OFS;
   wire hit_addr = paddr == `LFC_ADDR_OFS;
   wire hit_wdata = paddr == `LFC_WDATA_OFS;
   wire hit_stat = paddr == `LFC_STAT_OFS;
   wire hit_rdata = paddr == `LFC_RDATA_OFS;
   wire hit_any = hit_ctrl | hit_addr | hit_wdata | hit_stat | hit_rdata;
   wire idle = state == lfc_idle;
   wire go = apb_wr && hit_ctrl && pwdata[`LFC_CTRL_GO] && idle;
   wire [3:0] op = ctrl[`LFC_CTRL_OP_MSB:`LFC_CTRL_OP_LSB];
   wire [7:0] cmd = ctrl[`LFC_CTRL_CMD_MSB:`LFC_CTRL_CMD_LSB];
   wire dev_ready = rb_s2; // pin pulled up externally when floated
   wire [31:0] stat_word = {28'h0000000, err, done, dev_ready, !idle};
   // single-cycle answer; unmapped addresses read zero with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit_any;
   assign busy_state = {!dev_ready, !idle};
   always_comb begin
      prdata = 32'h00000000;
      if (apb_rd_en && hit_ctrl) prdata = ctrl;
      else if (apb_rd_en && hit_addr) prdata = {13'h0000, addr};
      else if (apb_rd_en && hit_wdata) prdata = {16'h0000, wdata};
      else if (apb_rd_en && hit_stat) prdata = stat_word;
      else if (apb_rd_en && hit_rdata) prdata = {16'h0000, rdata};
   end

   // ============================================================
   // pin synchronisers: data bus and ready/busy come from another domain
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
      end else begin
         dq_s1 <= flash_dq_in;
         dq_s2 <= dq_s1;
         rb_s1 <= ready_busy_n;
         rb_s2 <= rb_s1;
      end
   end

   // ============================================================
   // software registers; done and err set wins over software clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= 32'h00000000;
         addr <= 19'h00000;
         wdata <= 16'h0000;
      end else if (apb_wr) begin
         if (hit_ctrl) ctrl <= {pwdata[31:1], 1'b0};
         if (hit_addr) addr <= pwdata[18:0]; // byte or word address
         if (hit_wdata) wdata <= pwdata[15:0];
      end
   end

   // ============================================================
   // pin sequencer: each command write is setup, low strobe, rising edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= lfc_idle;
         chip_select_n <= 1'b1; // standby
         output_gate_n <= 1'b1;
         write_strobe_n <= 1'b1;
         flash_dq_oe <= 1'b0;
         flash_dq_out <= 16'h0000;
         flash_addr <= 19'h00000;
         reset_powerdown_n <= 1'b0; // hold device in reset; aborts work
         byte_mode_n <= 1'b1;
         rdata <= 16'h0000;
         done <= 1'b0;
         err <= 1'b0;
         count <= 10'h000;
         writes_left <= 3'h0;
      end else begin
         byte_mode_n <= !ctrl[`LFC_CTRL_BYTE];
         if (apb_wr && hit_stat && pwdata[`LFC_STAT_DONE]) done <= 1'b0;
         if (apb_wr && hit_stat && pwdata[`LFC_STAT_ERR]) err <= 1'b0;
         if (apb_wr && hit_ctrl && pwdata[`LFC_CTRL_GO] && !idle) err <= 1'b1;
         case (state)
            lfc_idle: begin
               if (ctrl[`LFC_CTRL_PD]) begin
                  reset_powerdown_n <= 1'b0; // deep power-down
               end else if (!reset_powerdown_n) begin
                  reset_powerdown_n <= 1'b1;
                  count <= 10'(`LFC_RECOVERY_CYC);
                  state <= lfc_recover;
               end else if (go) begin
                  // every op except a status read is refused until ready
                  if (!dev_ready && pwdata[`LFC_CTRL_OP_MSB:`LFC_CTRL_OP_LSB] != 4'(lfc_op_status))
                     err <= 1'b1;
                  else begin
                     state <= lfc_setup;
                     writes_left <= 3'h1;
                  end
               end
            end
            lfc_recover: begin
               // no read is launched until recovery ends
               if (count == 10'h000) state <= lfc_idle;
               else count <= count - 10'h001;
            end
            lfc_setup: begin
               chip_select_n <= 1'b0;
               output_gate_n <= 1'b1;
               if (op == 4'(lfc_op_read) || op == 4'(lfc_op_status)) begin
                  flash_dq_oe <= 1'b0;
                  output_gate_n <= 1'b0; // read: gate low, strobe high
                  count <= 10'(`LFC_ACCESS_CYC);
                  state <= lfc_rwait;
               end else begin
                  // command byte or data word on the bus
                  flash_dq_oe <= 1'b1;
                  flash_dq_out <= (op == 4'(lfc_op_cmd1)) ? {8'h00, cmd} : wdata;
                  // confirm cycles of protect set/reset use the fixed address
                  flash_addr <= (op == 4'(lfc_op_cmd3)) ? `LFC_PROTECT_ADDR : addr;
                  write_strobe_n <= 1'b0;
                  count <= 10'(`LFC_STROBE_CYC);
                  state <= lfc_strobe;
               end
            end
            lfc_strobe: begin
               if (count == 10'h000) begin
                  write_strobe_n <= 1'b1; // device latches on this rise
                  count <= 10'(`LFC_STROBE_CYC);
                  state <= lfc_hold;
               end else count <= count - 10'h001;
            end
            lfc_hold: begin
               if (count == 10'h000) begin
                  flash_dq_oe <= 1'b0;
                  chip_select_n <= 1'b1;
                  state <= lfc_next;
               end else count <= count - 10'h001;
            end
            lfc_rwait: begin
               flash_addr <= addr; // low bit picks maker/device code in id mode
               if (count == 10'h000) begin
                  // status bit 7 is the ready flag
                  rdata <= (op == 4'(lfc_op_status)) ? {8'h00, dq_s2[7:0]} : dq_s2;
                  output_gate_n <= 1'b1;
                  chip_select_n <= 1'b1;
                  state <= lfc_next;
               end else count <= count - 10'h001;
            end
            lfc_next: begin
               done <= 1'b1;
               writes_left <= 3'h0;
               state <= lfc_idle;
            end
            default: state <= lfc_idle;
         endcase
      end
   end
endmodule

/* File: hdl/lfc_regs.svh */
// register offsets, field positions and timing counts of the flash bus controller
// ============================================================
`ifndef LFC_REGS_SVH
`define LFC_REGS_SVH
// ============================================================
// register offsets (byte addresses)
`define LFC_CTRL_OFS 12'h000
`define LFC_ADDR_OFS 12'h004
`define LFC_WDATA_OFS 12'h008
`define LFC_STAT_OFS 12'h00c
`define LFC_RDATA_OFS 12'h010
// ctrl fields
`define LFC_CTRL_GO 0
`define LFC_CTRL_OP_LSB 1
`define LFC_CTRL_OP_MSB 4
`define LFC_CTRL_BYTE 5
`define LFC_CTRL_PD 6
`define LFC_CTRL_CMD_LSB 8
`define LFC_CTRL_CMD_MSB 15
// status fields
`define LFC_STAT_BUSY 0
`define LFC_STAT_RDY 1
`define LFC_STAT_DONE 2
`define LFC_STAT_ERR 3
// command codes and timing
`define LFC_CMD_CONFIRM 8'hd0
`define LFC_CMD_READ_ARRAY 8'hff
`define LFC_PROTECT_ADDR 19'h000ff
`define LFC_RECOVERY_NS 750
`define LFC_CLK_NS 4
`define LFC_RECOVERY_CYC ((`LFC_RECOVERY_NS + `LFC_CLK_NS - 1) / `LFC_CLK_NS)
`define LFC_STROBE_CYC 16
`define LFC_ACCESS_CYC 48
`endif

/* File: hdl/lfc_pkg.sv */
// types shared by the flash bus controller
package lfc_pkg;
   // host-level operations that software requests
   typedef enum logic [3:0] {
      lfc_op_cmd1, lfc_op_cmd2, lfc_op_cmd3, lfc_op_read, lfc_op_status, lfc_op_raw
   } lfc_op_t;
   typedef enum logic [3:0] {
      lfc_idle, lfc_recover, lfc_setup, lfc_strobe, lfc_hold, lfc_rsetup, lfc_rwait,
      lfc_next
   } lfc_state_t;
endpackage

/* File: sim/lfc_host_checker.sv */
// concurrent checks on the flash controller's pins and apb port
`timescale 1ns/100ps
module lfc_host_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [18:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe,
   input wire logic chip_select_n,
   input wire logic output_gate_n,
   input wire logic write_strobe_n,
   input wire logic reset_powerdown_n
);
   logic [7:0] rc;
   // ============================================================
   // cycles since the pin rose, saturating; two cycles of slack for sync
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n || !reset_powerdown_n) rc <= 8'h0;
      else if (rc != 8'hff) rc <= rc + 8'h1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_no_fight: assert property (!output_gate_n |-> !flash_dq_oe && write_strobe_n)
      else $error("gate low while bus driven");
   a_write_cycle: assert property (!write_strobe_n |-> !chip_select_n && flash_dq_oe
      && output_gate_n) else $error("bad write cycle pins");
   a_latch_stable: assert property ($rose(write_strobe_n) |-> $stable(flash_dq_out)
      && $stable(flash_addr)) else $error("data moved at strobe rise");
   a_strobe_width: assert property ($fell(write_strobe_n) |-> ##16 !write_strobe_n)
      else $error("strobe too short");
   a_standby_quiet: assert property (chip_select_n |-> write_strobe_n && output_gate_n)
      else $error("strobe while deselected");
   a_recovery_wait: assert property (!chip_select_n |-> rc >= 8'd186)
      else $error("access inside recovery");
   a_pd_idle: assert property (!reset_powerdown_n |-> chip_select_n && !flash_dq_oe)
      else $error("access in power-down");
   a_apb_answer: assert property (psel && penable |-> pready)
      else $error("no ready");
   a_unmapped: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
      else $error("no slave error");
endmodule
bind lfc_host lfc_host_checker chk (.*);

/* File: sim/lfc_flash_model.sv */
// behavioural flash device answering the controller's pins
`timescale 1ns/100ps
module lfc_flash_model #(
   parameter int BUSY_NS = 2000,
   parameter logic [15:0] MAKER_ID = 16'h0a5a, // arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h0c3c // arbitrary value
) (
   input wire logic [18:0] flash_addr, // 512K byte locations
   input wire logic [15:0] flash_dq_out,
   output logic [15:0] flash_dq_in,
   input wire logic chip_select_n,
   input wire logic output_gate_n,
   input wire logic write_strobe_n,
   input wire logic reset_powerdown_n,
   output logic ready_busy_n
);
   logic [7:0] cmd = 8'hff;
   logic busy = 1'b0;
   logic [15:0] mem = 16'h0;
   logic [15:0] rdv;
   // ============================================================
   // latch on strobe rise; writes while busy are ignored
   always @(posedge write_strobe_n or negedge reset_powerdown_n) begin
      if (!reset_powerdown_n) begin
         cmd <= 8'hff;
         busy <= 1'b0;
      end else if (!chip_select_n && !busy) begin
         if (cmd == 8'h40) begin
            mem <= flash_dq_out;
            busy <= 1'b1;
            busy <= #BUSY_NS 1'b0;
         end
         cmd <= (cmd == 8'h40) ? 8'h70 : flash_dq_out[7:0];
      end
   end
   assign rdv = (cmd == 8'h70) ? {8'h0, !busy, 7'h0} :
      (cmd == 8'h90) ? (flash_addr[0] ? DEVICE_ID : MAKER_ID) : mem;
   // a floated bus shows the inverse so stale data never passes
   assign flash_dq_in = (reset_powerdown_n && !chip_select_n && !output_gate_n) ? rdv : ~rdv;
   assign ready_busy_n = busy ? 1'b0 : 1'b1;
endmodule

/* File: sim/lfc_host_tb.sv */
// self-checking bench for the flash bus controller
`timescale 1ns/100ps
`include "lfc_regs.svh"
module lfc_host_tb;
   localparam logic [15:0] MK = 16'h0a5a;
   localparam logic [15:0] DV = 16'h0c3c;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [31:0] prdata;
   logic pready, pslverr, flash_dq_oe, chip_select_n, output_gate_n, write_strobe_n;
   logic byte_mode_n, reset_powerdown_n, ready_busy_n;
   logic [18:0] flash_addr;
   logic [15:0] flash_dq_in, flash_dq_out;
   logic [1:0] busy_state;
   int n_mismatch = 0, tests_run = 0;
   lfc_host uut (.*);
   lfc_flash_model #(.MAKER_ID(MK), .DEVICE_ID(DV)) dev (.*);
   initial begin
      forever #2 clock = ~clock;
   end
   // ============================================================
   // apb master: hold the request until pready is seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // start one flash op, wait for done, then clear done
   task op(input logic [3:0] o, input logic [7:0] c);
      apb(1, `LFC_CTRL_OFS, {16'h0, c, 3'h0, o, 1'b1});
      do apb(0, `LFC_STAT_OFS, 0); while (rd[`LFC_STAT_DONE] !== 1'b1);
      apb(1, `LFC_STAT_OFS, 32'h4);
   endtask
   task rd_at(input logic [31:0] a);
      apb(1, `LFC_ADDR_OFS, a);
      op(3, 0);
      apb(0, `LFC_RDATA_OFS, 0);
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task summarize;
      if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task t_ident;
      apb(0, 12'h020, 0);
      chk(rd, 32'h00000000);
      chk({31'h00000000, err}, 32'h00000001);
      op(0, 8'h90);
      rd_at(0);
      chk(rd[15:0], MK);
      rd_at(1);
      chk(rd[15:0], DV);
   endtask
   task t_prog;
      op(0, 8'h40);
      apb(1, `LFC_WDATA_OFS, 32'h1234);
      op(1, 0);
      apb(0, `LFC_STAT_OFS, 0);
      chk(rd[`LFC_STAT_RDY], 0);
      chk({30'h00000000, busy_state}, 32'h00000002);
      // only the status read is let through while the device is busy
      apb(1, `LFC_ADDR_OFS, 5);
      op(4, 0);
      apb(0, `LFC_RDATA_OFS, 0);
      chk(rd[7], 0);
      repeat (600) @(posedge clock);
      apb(0, `LFC_STAT_OFS, 0);
      chk(rd[`LFC_STAT_RDY], 1);
      rd_at(5);
      chk(rd[7], 1);
      op(0, 8'hff);
      rd_at(5);
      chk(rd[15:0], 16'h1234);
   endtask
   // power-down in mid program must abort it
   task t_pd;
      op(0, 8'h40);
      op(1, 0);
      apb(1, `LFC_CTRL_OFS, 32'h40);
      repeat (5) @(posedge clock);
      apb(0, `LFC_STAT_OFS, 0);
      chk(rd[`LFC_STAT_RDY], 1);
      apb(1, `LFC_CTRL_OFS, 0);
      repeat (200) @(posedge clock);
      op(0, 8'h70);
      rd_at(0);
      chk(rd[7], 1);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1;
      repeat (200) @(posedge clock);
      t_ident();
      t_prog();
      t_pd();
      summarize();
   end
   initial begin
      #200000;
      n_mismatch++;
      summarize();
   end
endmodule
